/* File: src/vrc_pkg.sv */
// constants, carriers and register map for the virtual reset / cancel-delay block
// assumes a single 40 MHz clock and an apb slave for software access
// Function
// - each virtual reset and cancel-delay owns its own request bit; here cancel-delay shares bit 0 with virtual reset 0
// - a request acts only when the written code equals the configured code
// - the configured code sits with network settings, outside the checksum
// - a written code is effective only up to 2 seconds after first written
// - a matching code is echoed in the enable feedback register, about 125 ms
// - result feedback reports acceptance, about 175 ms
// - act only after the full set, code, clear order within limits
// - cancel-delay uses exactly the same handshake as manual reset
// - accepted reset resets blocks configured for manual reset
// - keep-on cancel holds the off-delayed output on
// - turn-off cancel switches the delayed or one-shot output off at once
// - control-input cancel keeps output on if the input returns in time
// - drive delay-in-progress status while a cancel can still keep it on
// - on/off input: 1 run, 0 stop, acts only while safety inputs run
// - unmapped on/off input still drives a status output
// - press-control mode select uses three separate on/off inputs
// - mute allowed only while configured mute-enable level is 1
// - reset to a block is ignored while its controlling inputs stop
package vrc_pkg;

    localparam int unsigned N_REQ      = 8;
    localparam int unsigned CLK_HZ     = 40_000_000;
    localparam int unsigned CODE_MS    = 2000;   // code lifetime
    localparam int unsigned ECHO_MS    = 125;    // least hold after code
    localparam int unsigned RESULT_MS  = 175;    // result feedback bound
    localparam int unsigned CODE_CYC   = CLK_HZ / 1000 * CODE_MS;
    localparam int unsigned ECHO_CYC   = (CLK_HZ / 1000 * ECHO_MS);
    localparam int unsigned CNT_W      = 27;

    // register byte offsets
    localparam logic [11:0] OFS_REQ      = 12'h000;
    localparam logic [11:0] OFS_ENABLE   = 12'h004;
    localparam logic [11:0] OFS_EN_FB    = 12'h008;
    localparam logic [11:0] OFS_RESULT   = 12'h00c;
    localparam logic [11:0] OFS_CODE_CFG = 12'h010;
    localparam logic [11:0] OFS_LEVELS   = 12'h014;
    localparam logic [11:0] OFS_CANCEL   = 12'h018;
    localparam logic [11:0] OFS_STATUS   = 12'h01c;

    // level bits in the levels register
    localparam int unsigned LVL_ONOFF0 = 0;   // three on/off inputs at 0..2
    localparam int unsigned LVL_MUTE   = 3;
    localparam int unsigned LVL_MUTE_CFG = 4;

    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        CK_KEEP_ON  = 2'b00,
        CK_TURN_OFF = 2'b01,
        CK_CTRL_IN  = 2'b10,
        CK_NONE     = 2'b11
    } cancel_kind_t;

    typedef enum logic [2:0] {
        HS_IDLE  = 3'b000,
        HS_ARMED = 3'b001,
        HS_CODE  = 3'b010,
        HS_CLEAR = 3'b011,
        HS_BLOCK = 3'b100
    } hs_state_t;

    // apb request carrier
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } apb_req_t;

endpackage : vrc_pkg

/* File: src/vrc_delay_out.sv */
// one off-delayed safety output with cancel handling
// assumes delay given in cycles and a one-cycle cancel pulse from the handshake
`timescale 1ns/1ps
`default_nettype none
module vrc_delay_out
    import vrc_pkg::*;
#(
    parameter int unsigned W = CNT_W
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // control
    input  wire logic         ctrl_run,
    input  wire logic [W-1:0] delay_cyc,
    input  wire cancel_kind_t kind,
    input  wire logic         cancel,
    // outputs
    output logic              out_on,
    output logic              in_delay
);
    logic         on_ff, nxt_on;
    logic         held_ff, nxt_held;
    logic [W-1:0] cnt_ff, nxt_cnt;

    // off-delay timer with cancel variants; a returning input does not freeze a
    // running delay unless the kind is control input, so no shortened delay later
    always_comb begin
        nxt_on   = on_ff;
        nxt_held = held_ff;
        nxt_cnt  = cnt_ff;
        if (ctrl_run && (cnt_ff == '0 || kind == CK_CTRL_IN || held_ff)) begin
            nxt_on  = 1'b1;
            nxt_cnt = '0;
        end else if (on_ff && !held_ff) begin
            if (cancel && kind == CK_TURN_OFF) begin
                nxt_on  = 1'b0;
                nxt_cnt = '0;
            end else if (cancel && kind == CK_KEEP_ON) begin
                nxt_held = 1'b1;
            end else if (cnt_ff + W'(1) >= delay_cyc) begin
                nxt_on  = 1'b0;
                nxt_cnt = '0;
            end else begin
                nxt_cnt = cnt_ff + W'(1);
            end
        end
        if (ctrl_run) begin
            nxt_held = 1'b0;
        end
    end

    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_ff   <= 1'b0;
            held_ff <= 1'b0;
            cnt_ff  <= '0;
        end else begin
            on_ff   <= nxt_on;
            held_ff <= nxt_held;
            cnt_ff  <= nxt_cnt;
        end
    end

    assign out_on   = on_ff;
    assign in_delay = on_ff && !ctrl_run && !held_ff;
endmodule : vrc_delay_out
`default_nettype wire

/* File: src/vrc_top.sv */
// virtual reset / cancel-delay handshake with apb register access
// assumes a networked master writes the registers over apb, one clock
`timescale 1ns/1ps
`default_nettype none
module vrc_top
    import vrc_pkg::*;
#(
    parameter int unsigned CODE_LIMIT = CODE_CYC,
    parameter int unsigned ECHO_MIN   = ECHO_CYC,
    parameter int unsigned DLY_CYC    = ECHO_CYC
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // safety side
    input  wire logic [N_REQ-1:0]  block_run,
    output logic [N_REQ-1:0]       manual_reset,
    output logic                   out_on,
    output logic                   delay_in_progress,
    output logic [2:0]             onoff_level,
    output logic                   onoff_status,
    output logic                   mute_allowed
);
    localparam int unsigned RST_IDX = 0; // cancel-delay request bit index

    apb_req_t           req;
    logic [N_REQ-1:0]   reqb_ff, nxt_reqb;
    logic [31:0]        enable_ff, nxt_enable;
    logic [31:0]        code_cfg_ff, nxt_code_cfg;
    logic [31:0]        echo_ff, nxt_echo;
    logic [N_REQ-1:0]   result_ff, nxt_result;
    logic [4:0]         levels_ff, nxt_levels;
    cancel_kind_t       kind_ff, nxt_kind;
    hs_state_t          st_ff, nxt_st;
    logic [CNT_W-1:0]   age_ff, nxt_age;
    logic [N_REQ-1:0]   latched_ff, nxt_latched;
    logic [N_REQ-1:0]   rst_ff, nxt_rst;
    logic               cancel_ff, nxt_cancel;
    logic [31:0]        prdata_ff, nxt_prdata;
    logic               pready_ff, nxt_pready;
    logic               pslverr_ff, nxt_pslverr;
    logic [2:0]         onoff_ff, nxt_onoff;
    logic               stat_ff, nxt_stat;
    logic               mute_ff, nxt_mute;
    logic               dip_ff, nxt_dip;
    logic               oon_ff, nxt_oon;
    logic               wr, rd, code_ok, acc;
    logic               dly_on, dly_busy;

    assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
    assign wr  = req.sel && req.enable && req.write && !pready_ff;
    assign rd  = req.sel && req.enable && !req.write && !pready_ff;

    // code valid only when configured (non-zero) and equal
    assign code_ok = (code_cfg_ff != RST_WORD) && (enable_ff == code_cfg_ff);

    // register writes and apb answer, one wait state
    always_comb begin
        nxt_reqb     = reqb_ff;
        nxt_enable   = enable_ff;
        nxt_code_cfg = code_cfg_ff;
        nxt_levels   = levels_ff;
        nxt_kind     = kind_ff;
        nxt_prdata   = prdata_ff;
        nxt_pslverr  = 1'b0;
        nxt_pready   = 1'b0;
        if (wr) begin
            nxt_pready = 1'b1;
            case (req.addr)
                OFS_REQ:      nxt_reqb = req.wdata[N_REQ-1:0];
                OFS_ENABLE:   nxt_enable = req.wdata;
                OFS_CODE_CFG: nxt_code_cfg = req.wdata;
                OFS_LEVELS:   nxt_levels = req.wdata[4:0];
                OFS_CANCEL:   nxt_kind = cancel_kind_t'(req.wdata[1:0]);
                OFS_EN_FB, OFS_RESULT, OFS_STATUS: nxt_pslverr = 1'b0;
                default:      nxt_pslverr = 1'b1;
            endcase
        end else if (rd) begin
            nxt_pready = 1'b1;
            case (req.addr)
                OFS_REQ:      nxt_prdata = {{(32-N_REQ){1'b0}}, reqb_ff};
                OFS_ENABLE:   nxt_prdata = enable_ff;
                OFS_EN_FB:    nxt_prdata = echo_ff;
                OFS_RESULT:   nxt_prdata = {{(32-N_REQ){1'b0}}, result_ff};
                OFS_CODE_CFG: nxt_prdata = RST_WORD; // code is write-only
                OFS_LEVELS:   nxt_prdata = {27'h000_0000, levels_ff};
                OFS_CANCEL:   nxt_prdata = {30'h0000_0000, kind_ff};
                OFS_STATUS:   nxt_prdata = {28'h000_0000, dly_busy, dly_on,
                                            3'(st_ff) == 3'(HS_BLOCK), 1'b0};
                default: begin
                    nxt_prdata  = RST_WORD;
                    nxt_pslverr = 1'b1;
                end
            endcase
        end
    end

    // handshake sequencer shared by reset and cancel bits
    always_comb begin
        nxt_st      = st_ff;
        nxt_age     = age_ff;
        nxt_echo    = echo_ff;
        nxt_result  = result_ff;
        nxt_latched = latched_ff;
        nxt_rst     = '0;
        nxt_cancel  = 1'b0;
        acc         = 1'b0;
        case (st_ff)
            HS_IDLE: begin
                nxt_echo = RST_WORD;
                if (reqb_ff != '0 && enable_ff == RST_WORD) begin
                    nxt_st = HS_ARMED;
                end else if (enable_ff != RST_WORD) begin
                    nxt_st = HS_BLOCK;
                end
            end
            HS_ARMED: begin
                if (reqb_ff == '0) begin
                    nxt_st = HS_IDLE;
                end else if (enable_ff != RST_WORD) begin
                    nxt_age     = '0;
                    nxt_latched = reqb_ff;
                    nxt_result  = '0;
                    nxt_st      = code_ok ? HS_CODE : HS_BLOCK;
                end
            end
            HS_CODE: begin
                nxt_age  = age_ff + CNT_W'(1);
                nxt_echo = enable_ff;
                if (age_ff >= CNT_W'(CODE_LIMIT)) begin
                    nxt_st = HS_BLOCK;
                end else if (reqb_ff != latched_ff && reqb_ff != '0) begin
                    nxt_st = HS_BLOCK;
                end else if (reqb_ff == '0) begin
                    // clearing before the least hold breaks the order
                    nxt_st = (age_ff >= CNT_W'(ECHO_MIN) && code_ok) ? HS_CLEAR : HS_BLOCK;
                end else if (!code_ok) begin
                    nxt_st = HS_BLOCK;
                end
            end
            HS_CLEAR: begin
                nxt_age = age_ff + CNT_W'(1);
                if (age_ff >= CNT_W'(CODE_LIMIT) || reqb_ff != '0) begin
                    nxt_st = HS_BLOCK;
                end else if (enable_ff == RST_WORD) begin
                    acc        = 1'b1;
                    nxt_result = latched_ff;
                    nxt_rst    = latched_ff & block_run;
                    nxt_cancel = latched_ff[RST_IDX];
                    nxt_echo   = RST_WORD;
                    nxt_st     = HS_IDLE;
                end
            end
            HS_BLOCK: begin
                nxt_result = '0;
                nxt_echo   = RST_WORD;
                if (reqb_ff == '0 && enable_ff == RST_WORD) begin
                    nxt_st = HS_IDLE;
                end
            end
            default: nxt_st = HS_IDLE;
        endcase
    end

    // virtual levels and derived outputs
    always_comb begin
        nxt_onoff = levels_ff[LVL_ONOFF0 +: 3] & {3{block_run[0]}};
        nxt_stat  = levels_ff[LVL_ONOFF0];
        nxt_mute  = !levels_ff[LVL_MUTE_CFG] || levels_ff[LVL_MUTE];
        nxt_dip   = dly_busy;
        nxt_oon   = dly_on;
    end

    // the cancel-delay bit steers one off-delayed output
    vrc_delay_out #(
        .W(CNT_W)
    ) u_dly (
        .pclk     (pclk),
        .presetn  (presetn),
        .ctrl_run (block_run[0] && onoff_ff[0]),
        .delay_cyc(CNT_W'(DLY_CYC)),
        .kind     (kind_ff),
        .cancel   (cancel_ff),
        .out_on   (dly_on),
        .in_delay (dly_busy)
    );

    // all state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reqb_ff     <= '0;
            enable_ff   <= RST_WORD;
            code_cfg_ff <= RST_WORD;
            echo_ff     <= RST_WORD;
            result_ff   <= '0;
            levels_ff   <= '0;
            kind_ff     <= CK_NONE;
            st_ff       <= HS_IDLE;
            age_ff      <= '0;
            latched_ff  <= '0;
            rst_ff      <= '0;
            cancel_ff   <= 1'b0;
            prdata_ff   <= RST_WORD;
            pready_ff   <= 1'b0;
            pslverr_ff  <= 1'b0;
            onoff_ff    <= '0;
            stat_ff     <= 1'b0;
            mute_ff     <= 1'b0;
            dip_ff      <= 1'b0;
            oon_ff      <= 1'b0;
        end else begin
            reqb_ff     <= nxt_reqb;
            enable_ff   <= nxt_enable;
            code_cfg_ff <= nxt_code_cfg;
            echo_ff     <= nxt_echo;
            result_ff   <= nxt_result;
            levels_ff   <= nxt_levels;
            kind_ff     <= nxt_kind;
            st_ff       <= nxt_st;
            age_ff      <= nxt_age;
            latched_ff  <= nxt_latched;
            rst_ff      <= nxt_rst;
            cancel_ff   <= nxt_cancel;
            prdata_ff   <= nxt_prdata;
            pready_ff   <= nxt_pready;
            pslverr_ff  <= nxt_pslverr;
            onoff_ff    <= nxt_onoff;
            stat_ff     <= nxt_stat;
            mute_ff     <= nxt_mute;
            dip_ff      <= nxt_dip;
            oon_ff      <= nxt_oon;
        end
    end

    assign prdata            = prdata_ff;
    assign pready            = pready_ff;
    assign pslverr           = pslverr_ff;
    assign manual_reset      = rst_ff;
    assign out_on            = oon_ff;
    assign delay_in_progress = dip_ff;
    assign onoff_level       = onoff_ff;
    assign onoff_status      = stat_ff;
    assign mute_allowed      = mute_ff;
endmodule : vrc_top
`default_nettype wire

/* File: tb/vrc_top_checker.sv */
// concurrent checks on the ports of the virtual reset / cancel-delay block
// assumes one clock domain, pclk, and presetn as its asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module vrc_top_checker
    import vrc_pkg::*;
(
    // clock and reset
    input wire logic             pclk,
    input wire logic             presetn,
    // apb slave
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic             pready,
    input wire logic             pslverr,
    // safety side
    input wire logic [N_REQ-1:0] block_run,
    input wire logic [N_REQ-1:0] manual_reset,
    input wire logic             out_on,
    input wire logic             delay_in_progress,
    input wire logic [2:0]       onoff_level
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // apb answers after exactly one wait state, for one cycle
    AST_ANSWER: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer missing");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready held too long");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    // accepted reset: one-cycle pulse, only after the code is cleared, only to running blocks
    AST_RESET_PULSE: assert property (manual_reset != 8'h00 |=> manual_reset == 8'h00)
        else $error("manual reset longer than one cycle");
    AST_RESET_GATED: assert property ((manual_reset & ~block_run) == 8'h00)
        else $error("reset reached a stopped block");
    AST_RESET_AFTER_CLEAR: assert property (manual_reset != 8'h00 |->
        $past(psel && penable && pwrite && paddr == OFS_ENABLE && pwdata == 32'h0, 2))
        else $error("reset without a code clear");
    // on/off levels act only while the controlling inputs run
    AST_ONOFF_GATED: assert property (!block_run[0] [*2] |-> onoff_level == 3'b000)
        else $error("on/off level passed while stopped");
    AST_DELAY_OUT: assert property (delay_in_progress |-> out_on)
        else $error("delay shown with output off");

    // main scenarios
    COV_RESET: cover property (manual_reset != 8'h00);
    COV_REFUSED: cover property (pslverr);
    COV_CANCEL_OFF: cover property (delay_in_progress ##1 !out_on);
endmodule : vrc_top_checker

bind vrc_top vrc_top_checker u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .block_run, .manual_reset, .out_on, .delay_in_progress, .onoff_level
);
`default_nettype wire

/* File: tb/vrc_host_model.sv */
// networked controller model: apb master and the reset / cancel-delay handshake
// assumes tasks are called from the bench just after a rising pclk edge
`timescale 1ns/1ps
`default_nettype none
module vrc_host_model
    import vrc_pkg::*;
(
    // clock
    input  wire logic        pclk,
    // apb master
    output var apb_req_t     req,
    input  wire logic [31:0] prdata,
    input  wire logic        pready
);
    int gap = 0;   // idle cycles before each transfer, slows the master down

    // idle bus at time zero
    initial req = '0;

    // one apb transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        repeat (1 + gap) @(posedge pclk);
        req <= '{sel: 1'b1, enable: 1'b0, write: w, addr: a, wdata: d};
        @(posedge pclk);
        req.enable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        req.sel    <= 1'b0;
        req.enable <= 1'b0;
    endtask : xfer

    // request bits first, then the code
    task automatic rcd_set(input logic [7:0] bits, input logic [31:0] code);
        logic [31:0] r;
        xfer(1'b1, OFS_REQ, {24'h0000_00, bits}, r);
        xfer(1'b1, OFS_ENABLE, code, r);
    endtask : rcd_set

    // wait, clear the request bits, then the code
    task automatic rcd_clear(input int hold);
        logic [31:0] r;
        repeat (hold) @(posedge pclk);
        xfer(1'b1, OFS_REQ, 32'h0000_0000, r);
        xfer(1'b1, OFS_ENABLE, 32'h0000_0000, r);
    endtask : rcd_clear
endmodule : vrc_host_model
`default_nettype wire

/* File: tb/test_vrc_top.sv */
// self-checking bench for the virtual reset / cancel-delay block
// assumes the host model drives apb; reads and reset pulses are checked from queues
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
    $display("CHECK FAILED at %0t got %h expected %h", $time, a, e); end end
module test_vrc_top
    import vrc_pkg::*;
;
    logic             pclk;
    logic             presetn;
    apb_req_t         req;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [7:0]       block_run;
    logic [7:0]       manual_reset;
    logic             out_on;
    logic             delay_in_progress;
    logic [2:0]       onoff_level;
    logic             onoff_status;
    logic             mute_allowed;
    logic [32:0]      rq[$];
    logic [7:0]       mq[$];
    logic [15:0]      seed;
    logic [31:0]      code;
    logic [7:0]       bits;
    cancel_kind_t     kind;
    logic [32:0]      exp_rd;
    logic [7:0]       exp_mr;
    int               num_errors = 0;
    int               comparisons = 0;

    vrc_top #(.CODE_LIMIT(200), .ECHO_MIN(20), .DLY_CYC(50)) u_dut (
        .pclk, .presetn, .psel(req.sel), .penable(req.enable), .pwrite(req.write),
        .paddr(req.addr), .pwdata(req.wdata), .prdata, .pready, .pslverr, .block_run,
        .manual_reset, .out_on, .delay_in_progress, .onoff_level, .onoff_status,
        .mute_allowed
    );
    vrc_host_model u_host (.pclk, .req, .prdata, .pready);

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        u_host.xfer(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        logic [31:0] r;
        rq.push_back(e);
        u_host.xfer(1'b0, a, 32'h0000_0000, r);
    endtask : rd

    task automatic give_verdict;
        if (num_errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict

    // clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // read answers and reset pulses against the oldest note
    // each note is popped once into exp_rd or exp_mr, so a mismatch print cannot pop again
    always @(posedge pclk) begin
        if (req.sel && req.enable && !req.write && pready === 1'b1 && rq.size() > 0) begin
            exp_rd = rq.pop_front();
            `CHK({pslverr, prdata}, exp_rd)
        end
        if (presetn && manual_reset !== 8'h00) begin
            if (mq.size() == 0) `CHK(manual_reset, 8'h00)
            else begin
                exp_mr = mq.pop_front();
                `CHK(manual_reset, exp_mr)
            end
        end
    end

    // watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        give_verdict();
    end

    // main sequence
    initial begin
        presetn = 1'b0;
        block_run = 8'hff;
        seed = 16'ha13e;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_CANCEL, 33'h0_0000_0003);
        rd(12'h020, 33'h1_0000_0000);
        u_host.rcd_set(8'h01, 32'h0000_0001);
        u_host.rcd_clear(25);
        rd(OFS_RESULT, 33'h0_0000_0000);
        seed = lfsr_next(seed);
        code = {16'h0000, seed | 16'h0001};
        wr(OFS_CODE_CFG, code);
        rd(OFS_CODE_CFG, 33'h0_0000_0000);
        // every request bit, feedback method, last run with stopped blocks
        for (int i = 0; i < 9; i++) begin
            seed = lfsr_next(seed);
            u_host.gap = int'(seed[1:0]);
            bits = (i == 8) ? 8'hff : 8'h01 << i;
            block_run <= (i == 8) ? 8'h5a : 8'hff;
            mq.push_back((i == 8) ? 8'h5a : bits);
            u_host.rcd_set(bits, code);
            rd(OFS_EN_FB, {1'b0, code});
            u_host.rcd_clear(20);
            repeat (4) @(posedge pclk);
            rd(OFS_RESULT, {25'h0, bits});
        end
        // broken handshakes: early, late, code before bits, wrong code then right one
        u_host.gap = 0;
        block_run <= 8'hff;
        for (int k = 0; k < 4; k++) begin
            if (k == 2) wr(OFS_ENABLE, code);
            u_host.rcd_set(8'h03, (k == 3) ? code ^ 32'h0000_0001 : code);
            if (k == 3) wr(OFS_ENABLE, code);
            u_host.rcd_clear((k == 0) ? 0 : (k == 1) ? 250 : 25);
            repeat (4) @(posedge pclk);
            rd(OFS_RESULT, 33'h0_0000_0000);
        end
        // random on/off and mute levels
        for (int k = 0; k < 6; k++) begin
            seed = lfsr_next(seed);
            block_run <= {seed[12:6], seed[5]};
            wr(OFS_LEVELS, {27'h0, seed[4:0]});
            repeat (3) @(posedge pclk);
            `CHK(onoff_level, seed[2:0] & {3{seed[5]}})
            `CHK(onoff_status, seed[0])
            `CHK(mute_allowed, !seed[4] || seed[3])
        end
        // cancel of the off-delay for each kind, an earlier delay left to run out first
        block_run <= 8'hff;
        wr(OFS_LEVELS, 32'h0000_0001);
        repeat (60) @(posedge pclk);
        for (int k = 0; k < 4; k++) begin
            kind = (k == 0) ? CK_KEEP_ON : (k == 1) ? CK_TURN_OFF : (k == 2) ? CK_NONE : CK_CTRL_IN;
            wr(OFS_CANCEL, {30'h0, kind});
            repeat (5) @(posedge pclk);
            `CHK(out_on, 1'b1)
            u_host.rcd_set(8'h01, code);
            block_run <= 8'hfe;
            repeat (3) @(posedge pclk);
            `CHK(delay_in_progress, 1'b1)
            u_host.rcd_clear(20);
            repeat (3) @(posedge pclk);
            `CHK(out_on, kind != CK_TURN_OFF)
            if (kind == CK_CTRL_IN) block_run <= 8'hff; // input back before the delay ends
            repeat (60) @(posedge pclk);
            `CHK(out_on, kind == CK_KEEP_ON || kind == CK_CTRL_IN)
            block_run <= 8'hff;
        end
        // second reset in mid-run: the cancel kind register returns to its reset value
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_CANCEL, 33'h0_0000_0003);
        `CHK(32'(mq.size()), 32'h0000_0000)
        give_verdict();
    end
endmodule : test_vrc_top
`default_nettype wire
